//--- logic/rtpc_pkg.sv
// ============================================================
// shared constants and types
package rtpc_pkg;

  // sizes
  localparam int RTPC_N_STREAMS = 16;
  localparam int RTPC_N_BUF_EN  = 2;
  localparam int RTPC_IR_W      = 4;
  localparam int RTPC_DR_W      = 32;
  localparam int RTPC_SYNC_W    = 2;

  // instruction codes and capture pattern
  localparam logic [RTPC_IR_W-1:0] RTPC_IR_IDCODE  = 4'h1;
  localparam logic [RTPC_IR_W-1:0] RTPC_IR_BYPASS  = 4'hf;
  localparam logic [RTPC_IR_W-1:0] RTPC_IR_CAPTURE = 4'h1;

  // identity value, arbitrary, bit 0 set as the scan chain expects
  localparam logic [RTPC_DR_W-1:0] RTPC_IDCODE_DEFAULT = 32'h0000_0001;

  // reset values of the pin state
  localparam logic RTPC_STREAM_RST_DATA = 1'b1;
  localparam logic RTPC_STREAM_RST_OE   = 1'b0;
  localparam logic RTPC_BUF_EN_RST      = 1'b0;
  localparam logic RTPC_TDO_RST_OE      = 1'b0;

  // test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } rtpc_tap_state_t;

endpackage : rtpc_pkg

//--- logic/rtpc_rst_ctl.sv
`timescale 1ns/1ps
// ============================================================
// device reset: async entry, synchronised release
module rtpc_rst_ctl #(
  parameter int N_BUF_EN = rtpc_pkg::RTPC_N_BUF_EN
) (
  // clock and resets
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic dev_rst_n_i,
  // carrier
  rtpc_rst_if.rst   rif
);
  import rtpc_pkg::*;

  if (N_BUF_EN < 1) begin : g_bad_width
    $error("rtpc_rst_ctl: N_BUF_EN must be at least 1");
  end

  typedef struct packed {
    logic [RTPC_SYNC_W-1:0] rel_s;
    logic [N_BUF_EN-1:0]    loc_en;
    logic [N_BUF_EN-1:0]    bkp_en;
  } rtpc_rst_st_t;

  localparam rtpc_rst_st_t ST_RST = '{
    rel_s:  '0,
    loc_en: {N_BUF_EN{RTPC_BUF_EN_RST}},
    bkp_en: {N_BUF_EN{RTPC_BUF_EN_RST}}
  };

  rtpc_rst_st_t q;
  rtpc_rst_st_t d;

  // ============================================================
  // next state: release shifts in, enables pass only out of reset
  always_comb begin
    d        = q;
    d.rel_s  = {q.rel_s[0], 1'b1};                          // RULE_12
    d.loc_en = q.rel_s[1] ? rif.core_loc_en : {N_BUF_EN{RTPC_BUF_EN_RST}}; // RULE_03
    d.bkp_en = q.rel_s[1] ? rif.core_bkp_en : {N_BUF_EN{RTPC_BUF_EN_RST}}; // RULE_11
    if (!rstn_i) begin
      d = ST_RST;
    end
  end

  // state register, cleared at once by the pin
  always_ff @(posedge clk_i or negedge dev_rst_n_i) begin
    if (!dev_rst_n_i) begin
      q <= ST_RST;                                           // RULE_01
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign rif.core_rst_n = q.rel_s[1];                       // RULE_04
  assign rif.loc_en     = q.loc_en;
  assign rif.bkp_en     = q.bkp_en;

  // ============================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_release;
    !dev_rst_n_i ##1 dev_rst_n_i [*3];
  endsequence

  a_enter_async: assert property ( // RULE_01 RULE_03
    !dev_rst_n_i |-> !rif.core_rst_n && rif.loc_en == '0 && rif.bkp_en == '0)
    else $error("reset pin low but outputs not in reset state");

  a_release_sync: assert property ( // RULE_12 RULE_01
    s_release |-> rif.core_rst_n && !$past(rif.core_rst_n) && !$past(rif.core_rst_n, 2))
    else $error("reset release not exactly two clocks after pin rise");

  a_bufen_follow: assert property ( // RULE_11
    (rif.core_rst_n && dev_rst_n_i ##1 dev_rst_n_i)
      |-> rif.loc_en == $past(rif.core_loc_en) && rif.bkp_en == $past(rif.core_bkp_en))
    else $error("buffer enables do not follow core out of reset");

  a_core_clear: assert property ( // RULE_04
    !rif.core_rst_n |=> rif.loc_en == '0 && rif.bkp_en == '0)
    else $error("enables not cleared while core held in reset");

endmodule // rtpc_rst_ctl

//--- logic/rtpc_rst_if.sv
`timescale 1ns/1ps
// ============================================================
// carrier between top and device reset control
interface rtpc_rst_if #(
  parameter int N_BUF_EN = rtpc_pkg::RTPC_N_BUF_EN
);
  logic [N_BUF_EN-1:0] core_loc_en;
  logic [N_BUF_EN-1:0] core_bkp_en;
  logic [N_BUF_EN-1:0] loc_en;
  logic [N_BUF_EN-1:0] bkp_en;
  logic                core_rst_n;

  modport top (output core_loc_en, output core_bkp_en,
               input  loc_en, input bkp_en, input core_rst_n);
  modport rst (input  core_loc_en, input core_bkp_en,
               output loc_en, output bkp_en, output core_rst_n);
endinterface // rtpc_rst_if

//--- logic/rtpc_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] device reset enters at once, asynchronously; leaves only on the internal clock
// [RULE_02] in reset, serial outputs are driven high or tri-stated per select pins
// [RULE_03] reset drives all per-channel buffer enable outputs low
// [RULE_04] reset clears every register and counter of the device; here device reset leaves the test port state untouched
// [RULE_05] test data out changes on each falling test clock edge
// [RULE_06] test data out is high impedance unless scan shifting is active
// [RULE_07] low test reset forces the controller to Test-Logic-Reset without clock edge
// [RULE_08] test equipment pulses test reset low at power-up for scan testing
// [RULE_09] system holds test reset low during normal switching operation
// [RULE_10] controller follows mode select on test clock; shifts instructions, data from input
// [RULE_11] low buffer enable disables external buffer, high enables it
// [RULE_12] reset release passes a two-stage synchroniser on the internal clock
// [RULE_13] test reset and device reset act independently of each other
// ============================================================
// reset and test port control top
module rtpc_top #(
  parameter int          N_STREAMS = rtpc_pkg::RTPC_N_STREAMS,
  parameter int          N_BUF_EN  = rtpc_pkg::RTPC_N_BUF_EN,
  parameter logic [31:0] IDCODE    = rtpc_pkg::RTPC_IDCODE_DEFAULT  // arbitrary value
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  // device reset pin and reset-state selects
  input  wire logic                 dev_rst_n_i,
  input  wire logic                 local_output_reset_state_select_i,
  input  wire logic                 backplane_output_reset_state_select_i,
  // switching core stream state
  input  wire logic [N_STREAMS-1:0] core_local_data_i,
  input  wire logic [N_STREAMS-1:0] core_local_oe_i,
  input  wire logic [N_STREAMS-1:0] core_backplane_data_i,
  input  wire logic [N_STREAMS-1:0] core_backplane_oe_i,
  input  wire logic [N_BUF_EN-1:0]  core_local_buf_en_i,
  input  wire logic [N_BUF_EN-1:0]  core_backplane_buf_en_i,
  // test port pins
  input  wire logic                 tck_i,
  input  wire logic                 tms_i,
  input  wire logic                 tdi_i,
  input  wire logic                 trst_n_i,
  // serial stream pins
  output logic [N_STREAMS-1:0]      local_serial_output_streams_o,
  output logic [N_STREAMS-1:0]      local_serial_output_streams_oe_o,
  output logic [N_STREAMS-1:0]      backplane_serial_output_streams_o,
  output logic [N_STREAMS-1:0]      backplane_serial_output_streams_oe_o,
  // external buffer enables
  output logic [N_BUF_EN-1:0]       local_channel_buffer_enables_o,
  output logic [N_BUF_EN-1:0]       backplane_channel_buffer_enables_o,
  // core reset and test data out
  output logic                      core_rst_n_o,
  output logic                      tdo_o,
  output logic                      tdo_oe_o
);
  import rtpc_pkg::*;

  if (N_STREAMS < 1 || N_STREAMS > RTPC_N_STREAMS) begin : g_bad_streams
    $error("rtpc_top: N_STREAMS out of range");
  end

  // ============================================================
  // state
  typedef struct packed {
    logic [RTPC_SYNC_W-1:0] trst_s;
    logic [RTPC_SYNC_W-1:0] tck_s;
    logic [RTPC_SYNC_W-1:0] tms_s;
    logic [RTPC_SYNC_W-1:0] tdi_s;
    logic [RTPC_SYNC_W-1:0] lsel_s;
    logic [RTPC_SYNC_W-1:0] bsel_s;
    logic                   tck_prev;
    rtpc_tap_state_t        st;
    logic [RTPC_IR_W-1:0]   ir_sh;
    logic [RTPC_IR_W-1:0]   ir;
    logic [RTPC_DR_W-1:0]   dr_sh;
    logic                   tdo;
    logic                   tdo_oe;
    logic [N_STREAMS-1:0]   lst_d;
    logic [N_STREAMS-1:0]   lst_oe;
    logic [N_STREAMS-1:0]   bst_d;
    logic [N_STREAMS-1:0]   bst_oe;
  } rtpc_main_st_t;

  localparam rtpc_main_st_t ST_RST = '{
    trst_s: '0, tck_s: '0, tms_s: '0, tdi_s: '0, lsel_s: '0, bsel_s: '0,
    tck_prev: 1'b0, st: TAP_RESET, ir_sh: '0, ir: RTPC_IR_IDCODE, dr_sh: '0,
    tdo: 1'b0, tdo_oe: RTPC_TDO_RST_OE,
    lst_d: {N_STREAMS{RTPC_STREAM_RST_DATA}}, lst_oe: {N_STREAMS{RTPC_STREAM_RST_OE}},
    bst_d: {N_STREAMS{RTPC_STREAM_RST_DATA}}, bst_oe: {N_STREAMS{RTPC_STREAM_RST_OE}}
  };

  rtpc_main_st_t q;
  rtpc_main_st_t d;
  logic          tck_rise;
  logic          tck_fall;
  logic          in_dev_rst;

  // ============================================================
  // test access port state transitions
  function automatic rtpc_tap_state_t rtpc_tap_next(input rtpc_tap_state_t s,
                                                    input logic tms);
    case (s)
      TAP_RESET:    return tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     return tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   return tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   return tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: return tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: return tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: return tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: return tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   return tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   return tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   return tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: return tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: return tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: return tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: return tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   return tms ? TAP_SEL_DR   : TAP_IDLE;
      default:      return TAP_RESET;
    endcase
  endfunction

  // ============================================================
  // device reset control and carrier
  rtpc_rst_if #(.N_BUF_EN(N_BUF_EN)) rst_if ();

  assign rst_if.core_loc_en = core_local_buf_en_i;
  assign rst_if.core_bkp_en = core_backplane_buf_en_i;

  rtpc_rst_ctl #(
    .N_BUF_EN (N_BUF_EN)
  ) u_rst_ctl (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .dev_rst_n_i (dev_rst_n_i),
    .rif         (rst_if.rst)
  );

  // edges of the sampled test clock, from the second stage only
  assign tck_rise   = q.tck_s[1] & ~q.tck_prev;
  assign tck_fall   = ~q.tck_s[1] & q.tck_prev;
  assign in_dev_rst = ~rst_if.core_rst_n;

  // ============================================================
  // next state
  always_comb begin
    d          = q;
    d.trst_s   = {q.trst_s[0], trst_n_i};
    d.tck_s    = {q.tck_s[0], tck_i};
    d.tms_s    = {q.tms_s[0], tms_i};
    d.tdi_s    = {q.tdi_s[0], tdi_i};
    d.lsel_s   = {q.lsel_s[0], local_output_reset_state_select_i};
    d.bsel_s   = {q.bsel_s[0], backplane_output_reset_state_select_i};
    d.tck_prev = q.tck_s[1];

    // rising test clock: step controller, capture and shift
    if (tck_rise) begin
      d.st = rtpc_tap_next(q.st, q.tms_s[1]);                // RULE_10
      case (q.st)
        TAP_RESET:    d.ir    = RTPC_IR_IDCODE;
        TAP_CAP_IR:   d.ir_sh = RTPC_IR_CAPTURE;
        TAP_SHIFT_IR: d.ir_sh = {q.tdi_s[1], q.ir_sh[RTPC_IR_W-1:1]}; // RULE_10
        TAP_CAP_DR:   d.dr_sh = (q.ir == RTPC_IR_IDCODE) ? IDCODE : '0;
        TAP_SHIFT_DR: begin
          if (q.ir == RTPC_IR_IDCODE) begin
            d.dr_sh = {q.tdi_s[1], q.dr_sh[RTPC_DR_W-1:1]};
          end else begin
            d.dr_sh = {q.dr_sh[RTPC_DR_W-1:1], q.tdi_s[1]};   // one-bit bypass
          end
        end
        default: ;
      endcase
    end

    // falling test clock: drive data out, update instruction
    if (tck_fall) begin
      d.tdo    = (q.st == TAP_SHIFT_IR) ? q.ir_sh[0] : q.dr_sh[0];   // RULE_05
      d.tdo_oe = (q.st == TAP_SHIFT_DR) || (q.st == TAP_SHIFT_IR);    // RULE_06
      if (q.st == TAP_UPD_IR) begin
        d.ir = q.ir_sh;
      end
    end

    // test reset wins over the clock, device reset never touches it
    if (!q.trst_s[1]) begin
      d.st     = TAP_RESET;                                   // RULE_07 RULE_13
      d.ir     = RTPC_IR_IDCODE;
      d.tdo_oe = RTPC_TDO_RST_OE;                             // RULE_06
    end

    // serial streams: reset state per select pin, else core
    if (in_dev_rst) begin
      d.lst_d  = {N_STREAMS{RTPC_STREAM_RST_DATA}};           // RULE_02
      d.lst_oe = {N_STREAMS{q.lsel_s[1]}};
      d.bst_d  = {N_STREAMS{RTPC_STREAM_RST_DATA}};
      d.bst_oe = {N_STREAMS{q.bsel_s[1]}};                    // RULE_02
    end else begin
      d.lst_d  = core_local_data_i;
      d.lst_oe = core_local_oe_i;
      d.bst_d  = core_backplane_data_i;
      d.bst_oe = core_backplane_oe_i;
    end

    if (!rstn_i) begin
      d = ST_RST;                                             // RULE_04
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // ============================================================
  // outputs
  assign local_serial_output_streams_o        = q.lst_d;
  assign local_serial_output_streams_oe_o     = q.lst_oe;
  assign backplane_serial_output_streams_o    = q.bst_d;
  assign backplane_serial_output_streams_oe_o = q.bst_oe;
  assign local_channel_buffer_enables_o       = rst_if.loc_en;
  assign backplane_channel_buffer_enables_o   = rst_if.bkp_en;
  assign core_rst_n_o                         = rst_if.core_rst_n;
  assign tdo_o                                = q.tdo;
  assign tdo_oe_o                             = q.tdo_oe;

  // ============================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_trst_tlr_force: assert property ( // RULE_07 RULE_13
    !trst_n_i [*3] |=> q.st == TAP_RESET && !q.tdo_oe)
    else $error("test reset did not force Test-Logic-Reset");

  a_tdo_fall_only: assert property ( // RULE_05
    $changed(tdo_o) |-> $past(tck_fall))
    else $error("test data out changed off a falling test clock");

  a_tdo_hiz_idle: assert property ( // RULE_06
    (q.st == TAP_IDLE || q.st == TAP_RESET) |-> !tdo_oe_o)
    else $error("test data out driven outside shifting");

  a_tap_step: assert property ( // RULE_10
    (tck_rise && q.trst_s[1] && q.st == TAP_SHIFT_DR && q.tms_s[1])
      |=> q.st == TAP_EXIT1_DR)
    else $error("controller missed shift to exit step");

  a_ir_shift: assert property ( // RULE_10
    (tck_rise && q.trst_s[1] && q.st == TAP_SHIFT_IR)
      |=> q.ir_sh[RTPC_IR_W-1] == $past(q.tdi_s[1]))
    else $error("instruction shift did not take test data in");

  a_stream_rst_sel: assert property ( // RULE_02
    in_dev_rst |=> local_serial_output_streams_oe_o == {N_STREAMS{$past(q.lsel_s[1])}}
                && backplane_serial_output_streams_oe_o == {N_STREAMS{$past(q.bsel_s[1])}}
                && &local_serial_output_streams_o && &backplane_serial_output_streams_o)
    else $error("serial outputs not in selected reset state");

endmodule // rtpc_top

//--- verif/rtpc_partner.sv
`timescale 1ns/1ps
// ============================================================
// board reset source and scan test equipment
module rtpc_partner (
  // clock
  input  wire logic clk_i,
  // test data back from the device, with its drive enable
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  // driven pins
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_n_o,
  output logic      dev_rst_n_o
);
  // idle levels: test clock still, pulled-up pins high, test reset low
  initial begin
    tck_o       = 1'h0;
    tms_o       = 1'h1;
    tdi_o       = 1'h1;
    trst_n_o    = 1'h0;
    dev_rst_n_o = 1'h1;
  end

  // one 200 ns test clock: 1 cycle setup, 3 high, 4 low; tdo taken before and after fall
  task automatic tck_cycle(input logic tms, input logic tdi,
                           output logic tdo_hi, output logic tdo_lo);
    @(negedge clk_i);
    tms_o = tms;
    tdi_o = tdi;
    @(negedge clk_i);
    tck_o = 1'h1;
    repeat (3) @(negedge clk_i);
    tdo_hi = tdo_pin();
    tck_o  = 1'h0;
    repeat (3) @(negedge clk_i);
    tdo_lo = tdo_pin();
  endtask

  // pin level as seen: no pull on test data out, so an undriven pin reads inverted
  function automatic logic tdo_pin();
    return tdo_oe_i ? tdo_i : ~tdo_i;
  endfunction

  // test reset level, changed off the clock edge
  task automatic set_trst(input logic v);
    @(negedge clk_i);
    trst_n_o = v;
  endtask

  // device reset level, changed off the clock edge
  task automatic set_dev_rst(input logic v);
    @(negedge clk_i);
    dev_rst_n_o = v;
  endtask
endmodule // rtpc_partner

//--- verif/tb_rtpc_top.sv
`timescale 1ns/1ps
// ============================================================
// testbench for reset and test port control
module tb_rtpc_top;
  import rtpc_pkg::*;
  localparam int          N       = RTPC_N_STREAMS;
  localparam int          E       = RTPC_N_BUF_EN;
  localparam logic [31:0] ID_VAL  = 32'h0a5c_3e71;  // arbitrary value, bit 0 set
  localparam logic [3:0]  BYP_PAT = 4'hb;

  // ============================================================
  // signals
  logic         clk_i, rstn_i, sel_l, sel_b;
  logic [N-1:0] c_ld, c_loe, c_bd, c_boe, ls, ls_oe, bs, bs_oe;
  logic [E-1:0] c_lbe, c_bbe, lbe, bbe;
  logic         tck, tms, tdi, trst_n, dev_rst_n, core_rst_n, tdo, tdo_oe, th, tl;
  int           errors, comparisons, cycles;

  // ============================================================
  // clock, timeout and instances
  initial clk_i = 1'h0;
  always #12.5 clk_i = ~clk_i;

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  rtpc_top #(.IDCODE(ID_VAL)) u_rtpc_top (
    .clk_i(clk_i), .rstn_i(rstn_i), .dev_rst_n_i(dev_rst_n),
    .local_output_reset_state_select_i(sel_l), .backplane_output_reset_state_select_i(sel_b),
    .core_local_data_i(c_ld), .core_local_oe_i(c_loe),
    .core_backplane_data_i(c_bd), .core_backplane_oe_i(c_boe),
    .core_local_buf_en_i(c_lbe), .core_backplane_buf_en_i(c_bbe),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
    .local_serial_output_streams_o(ls), .local_serial_output_streams_oe_o(ls_oe),
    .backplane_serial_output_streams_o(bs), .backplane_serial_output_streams_oe_o(bs_oe),
    .local_channel_buffer_enables_o(lbe), .backplane_channel_buffer_enables_o(bbe),
    .core_rst_n_o(core_rst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe));

  rtpc_partner u_rtpc_partner (
    .clk_i(clk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .trst_n_o(trst_n), .dev_rst_n_o(dev_rst_n));

  // ============================================================
  // compare tasks and verdict
  task automatic chk1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one test clock period through the partner
  task automatic jt(input logic m, input logic d);
    u_rtpc_partner.tck_cycle(m, d, th, tl);
  endtask

  // ============================================================
  // scenarios
  // core values pass to the pins one cycle later, enables high mean buffer on
  task automatic t_follow();
    @(negedge clk_i);
    c_ld  = 16'h5a3c;
    c_loe = 16'hf00f;
    c_bd  = 16'h1234;
    c_boe = 16'h0ff0;
    c_lbe = 2'h2;
    c_bbe = 2'h1;
    @(negedge clk_i);
    chk16("local data", 16'h5a3c, ls);
    chk16("local oe", 16'hf00f, ls_oe);
    chk16("backplane data", 16'h1234, bs);
    chk16("backplane oe", 16'h0ff0, bs_oe);
    chk16("local enables", 16'h0002, {14'h0, lbe});
    chk16("backplane enables", 16'h0001, {14'h0, bbe});
  endtask

  // device reset with given select levels; with both selects low, scan is checked to keep working meanwhile
  task automatic t_dev_reset(input logic sl, input logic sb);
    @(negedge clk_i);
    {sel_l, sel_b} = {sl, sb};
    {c_ld, c_bd}   = '0;
    {c_loe, c_boe} = '1;
    {c_lbe, c_bbe} = '1;
    repeat (4) @(negedge clk_i);
    u_rtpc_partner.set_dev_rst(1'h0);
    #1;
    chk16("enables at reset", 16'h0000, {12'h0, lbe, bbe});
    chk1("core reset at entry", 1'h0, core_rst_n);
    repeat (2) @(negedge clk_i);
    chk16("local data in reset", 16'hffff, ls);
    chk16("local oe in reset", {N{sl}}, ls_oe);
    chk16("backplane data in reset", 16'hffff, bs);
    chk16("backplane oe in reset", {N{sb}}, bs_oe);
    if (!sl && !sb) begin
      t_idcode(5);
    end
    u_rtpc_partner.set_dev_rst(1'h1);
    #1;
    chk1("core reset before clock", 1'h0, core_rst_n);
    @(negedge clk_i);
    chk1("core reset first stage", 1'h0, core_rst_n);
    @(negedge clk_i);
    chk1("core reset released", 1'h1, core_rst_n);
    @(negedge clk_i);
    chk16("local oe after reset", 16'hffff, ls_oe);
    chk16("local enables after", 16'h0003, {14'h0, lbe});
    chk16("backplane enables after", 16'h0003, {14'h0, bbe});
  endtask

  // identity read; n_tms leading ones walk the controller to its reset state
  task automatic t_idcode(input int n_tms);
    repeat (n_tms) jt(1'h1, 1'h1);
    jt(1'h0, 1'h1);
    jt(1'h1, 1'h1);
    jt(1'h0, 1'h1);
    jt(1'h0, 1'h1);
    chk1("id bit 0", ID_VAL[0], tl);
    chk1("tdo oe shifting", 1'h1, tdo_oe);
    for (int i = 1; i < 32; i++) begin
      jt(1'h0, 1'h0);
      chk1("tdo before fall", ID_VAL[i-1], th);
      chk1("id bit", ID_VAL[i], tl);
    end
    jt(1'h1, 1'h0);
    chk1("tdo oe after exit", 1'h0, tdo_oe);
    jt(1'h1, 1'h0);
    jt(1'h0, 1'h0);
  endtask

  // bypass load, data through bypass, test reset in mid-shift
  task automatic t_bypass();
    jt(1'h1, 1'h1);
    jt(1'h1, 1'h1);
    jt(1'h0, 1'h1);
    jt(1'h0, 1'h1);
    chk1("ir capture bit", RTPC_IR_CAPTURE[0], tl);
    for (int i = 1; i < 4; i++) begin
      jt(1'h0, RTPC_IR_BYPASS[i-1]);
      chk1("ir capture bit", RTPC_IR_CAPTURE[i], tl);
    end
    jt(1'h1, RTPC_IR_BYPASS[3]);
    jt(1'h1, 1'h1);
    jt(1'h0, 1'h1);
    jt(1'h1, 1'h1);
    jt(1'h0, 1'h1);
    jt(1'h0, 1'h1);
    chk1("bypass capture", 1'h0, tl);
    for (int j = 0; j < 4; j++) begin
      jt(1'h0, BYP_PAT[j]);
      chk1("bypass data", BYP_PAT[j], tl);
    end
    u_rtpc_partner.set_trst(1'h0);
    repeat (5) @(negedge clk_i);
    chk1("tdo oe under test reset", 1'h0, tdo_oe);
    chk1("core reset untouched", 1'h1, core_rst_n);
    chk16("local oe untouched", 16'hffff, ls_oe);
    u_rtpc_partner.set_trst(1'h1);
    repeat (3) @(negedge clk_i);
    t_idcode(0);
  endtask

  // ============================================================
  // main sequence
  initial begin
    errors      = 0;
    comparisons = 0;
    cycles      = 0;
    rstn_i      = 1'h0;
    {sel_l, sel_b} = 2'h0;
    {c_ld, c_loe, c_bd, c_boe} = '0;
    {c_lbe, c_bbe} = '0;
    repeat (5) @(negedge clk_i);
    rstn_i = 1'h1;
    @(negedge clk_i);
    chk1("core reset after house reset", 1'h0, core_rst_n);
    repeat (2) @(negedge clk_i);
    t_follow();
    u_rtpc_partner.set_trst(1'h1);
    repeat (3) @(negedge clk_i);
    for (int k = 0; k < 4; k++) begin
      t_dev_reset(k[0], k[1]);
    end
    t_idcode(5);
    t_bypass();
    wrap_up();
  end
endmodule // tb_rtpc_top
